// file: common/udfm_map.svh
`ifndef UDFM_MAP_SVH
`define UDFM_MAP_SVH
// ----------------------------------------------------------------------
// Register numbers and reset values
// ----------------------------------------------------------------------
`define UDFM_REG_MEM_SEL 16'h0164
`define UDFM_MEM_SEL_RESET 16'h0000
`define UDFM_MEM_SEL_KEEP 16'h0001
`define UDFM_MEM_SEL_CLEAR 16'h0000
// ----------------------------------------------------------------------
// Selection codes
// ----------------------------------------------------------------------
`define UDFM_IN7_UPDOWN 8'h22
`define UDFM_INIT_A 8'h08
`define UDFM_INIT_B 8'h09
// ----------------------------------------------------------------------
// Pin bit positions in the synchroniser vectors
// ----------------------------------------------------------------------
`define UDFM_PIN_UP 0
`define UDFM_PIN_DOWN 1
`define UDFM_PIN_FWD 2
`define UDFM_PIN_REV 3
`define UDFM_PIN_INCH 4
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define UDFM_CLK_KHZ 20000
`define UDFM_HOLD_TIME_MS 5000
`define UDFM_HOLD_CYCLES (`UDFM_HOLD_TIME_MS * `UDFM_CLK_KHZ)
`endif

// file: common/udfm_pkg.sv
package udfm_pkg;
  typedef enum logic [0:0] {UDFM_IDLE, UDFM_RUN} udfm_st_e;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } udfm_tick_s;

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] filt;
    udfm_st_e st;
    logic boot;
    logic [15:0] freq;
    logic [15:0] saved;
    logic saved_ok;
    logic nv_wr;
    logic active;
    logic [15:0] mem_sel;
    logic [15:0] rdata;
    logic [31:0] hold_cnt;
  } udfm_state_s;
endpackage : udfm_pkg

// file: verilog/udfm_tick.sv
// Enable-pulse divider: one pulse every period_in cycles while enabled.
module udfm_tick (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic en_in,
  input wire logic [15:0] period_in,
  // Pulse
  output logic tick_out
);
  udfm_pkg::udfm_tick_s q_r;
  udfm_pkg::udfm_tick_s q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.tick = 1'b0;
    if (!en_in) begin
      q_nxt.cnt = 16'h0000;
    end else if (q_r.cnt + 16'h0001 >= period_in) begin
      // A period of zero behaves as one so the ramp never stalls.
      q_nxt.cnt = 16'h0000;
      q_nxt.tick = 1'b1;
    end else begin
      q_nxt.cnt = q_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign tick_out = q_r.tick;
endmodule : udfm_tick

// file: verilog/udfm_core.sv
`include "udfm_map.svh"

module udfm_core #(
  parameter logic [31:0] HOLD_CYCLES = `UDFM_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Terminal pins, asynchronous
  input wire logic up_request_input_in,
  input wire logic down_request_input_in,
  input wire logic run_fwd_in,
  input wire logic run_rev_in,
  input wire logic inching_cmd_in,
  // Settings from the parameter store
  input wire logic [7:0] multi_input7_function_select_in,
  input wire logic [15:0] max_frequency_setting_in,
  input wire logic [15:0] reference_upper_limit_in,
  input wire logic [15:0] min_output_frequency_setting_in,
  input wire logic [15:0] reference_lower_limit_in,
  input wire logic [15:0] inching_frequency_in,
  input wire logic [15:0] accel_period_in,
  input wire logic [15:0] decel_period_in,
  input wire logic remote_mode_in,
  // Parameter register port
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic param_init_wr_in,
  input wire logic [7:0] param_init_select_in,
  // Non-volatile store
  input wire logic [15:0] nv_freq_in,
  input wire logic nv_valid_in,
  // Results
  output logic [15:0] freq_out,
  output logic updown_active_out,
  output logic running_out,
  output logic [15:0] reg_rdata_out,
  output logic [15:0] nv_freq_out,
  output logic nv_valid_out,
  output logic nv_wr_out
);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [15:0] udfm_min(input logic [15:0] a,
                                           input logic [15:0] b);
    udfm_min = (a < b) ? a : b;
  endfunction : udfm_min

  function automatic logic [15:0] udfm_clamp(input logic [15:0] x,
                                             input logic [15:0] lo,
                                             input logic [15:0] hi);
    logic [15:0] y;
    y = (x < lo) ? lo : x;
    udfm_clamp = (y > hi) ? hi : y;
  endfunction : udfm_clamp

  udfm_pkg::udfm_state_s q_r;
  udfm_pkg::udfm_state_s q_nxt;
  logic [15:0] upper_w;
  logic [15:0] lower_w;
  logic [15:0] held_w;
  logic func_en_w;
  logic run_w;
  logic up_w;
  logic down_w;
  logic inch_w;
  logic ramp_w;
  logic tick_w;
  logic save_w;
  logic mem_on_w;

  assign upper_w = udfm_min(max_frequency_setting_in,
                            reference_upper_limit_in);
  assign lower_w = udfm_min(min_output_frequency_setting_in,
                            reference_lower_limit_in);
  assign held_w = udfm_clamp(q_r.freq, lower_w, upper_w);
  assign func_en_w =
    (multi_input7_function_select_in == `UDFM_IN7_UPDOWN);
  assign run_w = q_r.filt[`UDFM_PIN_FWD] | q_r.filt[`UDFM_PIN_REV];
  assign up_w = q_r.filt[`UDFM_PIN_UP];
  assign down_w = q_r.filt[`UDFM_PIN_DOWN];
  assign inch_w = q_r.filt[`UDFM_PIN_INCH] & remote_mode_in;
  assign mem_on_w = (q_r.mem_sel == `UDFM_MEM_SEL_KEEP);
  // Multi-step references have no input here at all, so they cannot act.
  assign ramp_w = (q_r.st == udfm_pkg::UDFM_RUN) && run_w && func_en_w &&
                  remote_mode_in && !inch_w && (up_w ^ down_w);
  assign save_w = (q_r.st == udfm_pkg::UDFM_RUN) && mem_on_w &&
                  (q_r.hold_cnt == HOLD_CYCLES - 32'h1);

  // --------------------------------------------------------------------
  // Ramp rate divider
  // --------------------------------------------------------------------
  udfm_tick u_tick (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .en_in(ramp_w),
    .period_in(up_w ? accel_period_in : decel_period_in),
    .tick_out(tick_w)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    q_nxt = q_r;
    q_nxt.nv_wr = 1'b0;
    // Three stages; a change counts only when stages two and three agree.
    q_nxt.s1 = {inching_cmd_in, run_rev_in, run_fwd_in,
                down_request_input_in, up_request_input_in};
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    for (int i = 0; i < 5; i++) begin
      if (q_r.s2[i] == q_r.s3[i]) begin
        q_nxt.filt[i] = q_r.s3[i];
      end
    end
    q_nxt.active = func_en_w;
    if (reg_wr_in && reg_addr_in == `UDFM_REG_MEM_SEL) begin
      q_nxt.mem_sel = reg_wdata_in;
    end
    q_nxt.rdata = (reg_addr_in == `UDFM_REG_MEM_SEL) ? q_r.mem_sel
                                                     : 16'h0000;
    if (!q_r.boot) begin
      // Saved frequency is restored once, just after reset release.
      q_nxt.boot = 1'b1;
      q_nxt.saved = nv_freq_in;
      q_nxt.saved_ok = nv_valid_in;
    end

    case (q_r.st)
      udfm_pkg::UDFM_IDLE: begin
        q_nxt.hold_cnt = 32'h0;
        q_nxt.freq = 16'h0000;
        if (run_w && func_en_w) begin
          q_nxt.st = udfm_pkg::UDFM_RUN;
          if (inch_w) begin
            q_nxt.freq = inching_frequency_in;
          end else if (mem_on_w && q_r.saved_ok) begin
            q_nxt.freq = udfm_clamp(q_r.saved, lower_w, upper_w);
          end else begin
            q_nxt.freq = udfm_clamp(lower_w, lower_w, upper_w);
          end
        end
      end
      udfm_pkg::UDFM_RUN: begin
        if (!run_w || !func_en_w) begin
          q_nxt.st = udfm_pkg::UDFM_IDLE;
          q_nxt.freq = 16'h0000;
          q_nxt.hold_cnt = 32'h0;
        end else if (inch_w) begin
          q_nxt.freq = inching_frequency_in;
          q_nxt.hold_cnt = 32'h0;
        end else begin
          q_nxt.freq = held_w;
          if (ramp_w && tick_w) begin
            if (up_w && held_w < upper_w) begin
              q_nxt.freq = held_w + 16'h0001;
            end else if (down_w && held_w > lower_w) begin
              q_nxt.freq = held_w - 16'h0001;
            end
          end
          if (ramp_w || !remote_mode_in || held_w != q_r.freq) begin
            q_nxt.hold_cnt = 32'h0;
          end else if (q_r.hold_cnt < HOLD_CYCLES) begin
            q_nxt.hold_cnt = q_r.hold_cnt + 32'h1;
          end
        end
      end
      default: begin
        q_nxt.st = udfm_pkg::UDFM_IDLE;
      end
    endcase

    // The select leaves reset off, so the boot load is spared for one edge.
    if (!mem_on_w && q_r.boot) begin
      q_nxt.saved_ok = 1'b0;
      q_nxt.saved = 16'h0000;
    end
    if (param_init_wr_in && (param_init_select_in == `UDFM_INIT_A ||
                             param_init_select_in == `UDFM_INIT_B)) begin
      q_nxt.saved_ok = 1'b0;
      q_nxt.saved = 16'h0000;
    end
    // A save in the same cycle as an init wins, so the event is kept.
    if (save_w) begin
      q_nxt.saved = q_r.freq;
      q_nxt.saved_ok = 1'b1;
      q_nxt.nv_wr = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r <= '0;
      q_r.mem_sel <= `UDFM_MEM_SEL_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign freq_out = q_r.freq;
  assign updown_active_out = q_r.active;
  assign running_out = (q_r.st == udfm_pkg::UDFM_RUN);
  assign reg_rdata_out = q_r.rdata;
  assign nv_freq_out = q_r.saved;
  assign nv_valid_out = q_r.saved_ok;
  assign nv_wr_out = q_r.nv_wr;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  func_enable_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    !func_en_w |=> !updown_active_out)
    else $error("up/down active without input 7 selection");

  ramp_up_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (ramp_w && tick_w && up_w && held_w < upper_w)
      |=> freq_out == $past(held_w) + 16'h0001)
    else $error("up request did not raise frequency");

  ramp_down_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (ramp_w && tick_w && down_w && held_w > lower_w)
      |=> freq_out == $past(held_w) - 16'h0001)
    else $error("down request did not lower frequency");

  hold_freq_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (running_out && run_w && func_en_w && !inch_w && up_w == down_w)
      |=> freq_out == $past(held_w))
    else $error("frequency moved while held");

  upper_bound_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (run_w && func_en_w && !inch_w) |=> freq_out <= $past(upper_w))
    else $error("frequency above upper bound");

  lower_bound_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (run_w && func_en_w && !inch_w && lower_w <= upper_w)
      |=> freq_out >= $past(lower_w))
    else $error("frequency below lower bound");

  start_low_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (!running_out && run_w && func_en_w && !inch_w &&
     !(mem_on_w && q_r.saved_ok) && lower_w <= upper_w)
      |=> running_out && freq_out == $past(lower_w))
    else $error("run did not start at lower limit");

  inch_prio_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (run_w && func_en_w && inch_w)
      |=> freq_out == $past(inching_frequency_in))
    else $error("inching did not override up/down");

  save_hold_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    nv_wr_out |-> $past(q_r.hold_cnt) == HOLD_CYCLES - 32'h1 &&
      nv_valid_out && nv_freq_out == $past(freq_out))
    else $error("save without a full hold time");

  mem_clear_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (!mem_on_w && q_r.boot) |=> !nv_valid_out)
    else $error("saved value kept with memory off");

  init_clear_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (q_r.boot && !save_w && param_init_wr_in &&
     param_init_select_in inside {`UDFM_INIT_A, `UDFM_INIT_B})
      |=> !nv_valid_out && nv_freq_out == 16'h0000)
    else $error("init did not clear saved frequency");

  local_hold_a: assert property (@(posedge ref_clk_in)
    disable iff (!rst_n_in)
    (running_out && run_w && func_en_w && !remote_mode_in)
      |=> freq_out == $past(held_w))
    else $error("frequency changed outside remote mode");
endmodule : udfm_core

// file: verification/udfm_switch_model.sv
// ----------------------------------------------------------------------
// Terminal switches driven by an outside controller
// ----------------------------------------------------------------------
// Contacts change only on the clock edge after a command changes, so the bench
// sees one cycle of pin lag from this model ahead of the device's own input filter.
module udfm_switch_model (
  // Clock
  input wire logic ref_clk_in,
  // Commands: rev, inch, run, down, up
  input wire logic [4:0] cmd_in,
  // Contacts
  output logic up_out,
  output logic down_out,
  output logic run_fwd_out,
  output logic run_rev_out,
  output logic inch_out
);
  timeunit 1ns;
  timeprecision 1ns;

  always @(posedge ref_clk_in) begin
    up_out <= cmd_in[0];
    down_out <= cmd_in[1];
    run_fwd_out <= cmd_in[2];
    inch_out <= cmd_in[3];
    run_rev_out <= cmd_in[4];
  end
endmodule : udfm_switch_model

// file: verification/updown_frequency_memory_tb.sv
module updown_frequency_memory_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] LO = 16'h0010;
  localparam logic [15:0] HI = 16'h0028;
  logic clk = 1'b0, rst_n = 1'b0, rem = 1'b0, wr = 1'b0, iwr = 1'b0;
  logic [4:0] cmd = 5'h00;
  logic [7:0] func = 8'h00, isel = 8'h00;
  logic [15:0] acc, dec, inch_f, addr = 16'h0000, wd = 16'h0000;
  logic [15:0] nvf_in, freq, rdata, nvf, fprev = 16'h0000;
  logic [15:0] fmax = 16'h0030;
  logic nvv_in = 1'b0;
  logic up, dn, fwd, rev, inch, act, run, nvv, nvw;
  logic [31:0] seed = 32'd67256;
  logic [15:0] exp_q[$];
  int err_total = 0, cmp_count = 0, saves = 0;

  always #25 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  udfm_switch_model pins (.ref_clk_in(clk), .cmd_in(cmd), .up_out(up),
    .down_out(dn), .run_fwd_out(fwd), .run_rev_out(rev), .inch_out(inch));

  udfm_core #(.HOLD_CYCLES(32'd20)) uut (.ref_clk_in(clk),
    .rst_n_in(rst_n), .up_request_input_in(up), .down_request_input_in(dn),
    .run_fwd_in(fwd), .run_rev_in(rev), .inching_cmd_in(inch),
    .multi_input7_function_select_in(func),
    .max_frequency_setting_in(fmax), .reference_upper_limit_in(HI),
    .min_output_frequency_setting_in(LO),
    .reference_lower_limit_in(16'h0014), .inching_frequency_in(inch_f),
    .accel_period_in(acc), .decel_period_in(dec), .remote_mode_in(rem),
    .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wd),
    .param_init_wr_in(iwr), .param_init_select_in(isel),
    .nv_freq_in(nvf_in), .nv_valid_in(nvv_in), .freq_out(freq),
    .updown_active_out(act), .running_out(run), .reg_rdata_out(rdata),
    .nv_freq_out(nvf), .nv_valid_out(nvv), .nv_wr_out(nvw));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  task automatic set_cmd(input logic [4:0] c);
    @(posedge clk) cmd <= c;
  endtask : set_cmd

  task automatic push_ramp(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] v;
    v = a;
    while (v != b) begin
      v = (a < b) ? v + 16'h0001 : v - 16'h0001;
      exp_q.push_back(v);
    end
  endtask : push_ramp

  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk) begin
      wr <= 1'b1;
      addr <= a;
      wd <= d;
    end
    @(posedge clk) wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk) addr <= a;
    step(2);
    #1 chk(rdata, e);
  endtask : reg_rd

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------------
  // Output watcher: each change of the frequency takes the oldest note
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst_n && freq !== fprev) begin
      if (exp_q.size() == 0) begin
        chk(freq, fprev);
      end else begin
        chk(freq, exp_q.pop_front());
      end
    end
    if (rst_n && nvw) begin
      saves++;
      chk(nvf, fprev);
    end
    fprev <= freq;
  end

  initial begin
    step(3000);
    err_total++;
    wrap_up();
  end

  initial begin
    acc = 16'(rnd() % 3 + 1);
    dec = 16'(rnd() % 3 + 1);
    inch_f = 16'(16'h0011 + rnd() % 23);
    nvf_in = 16'(rnd());
    step(20);
    rst_n <= 1'b1;
    step(2);
    reg_rd(16'h0164, 16'h0000);
    reg_wr(16'h0164, 16'h0001);
    reg_wr(16'h0165, 16'hffff);
    reg_rd(16'h0165, 16'h0000);
    reg_rd(16'h0164, 16'h0001);
    chk(16'(act), 16'h0000);
    @(posedge clk) begin
      func <= 8'h22;
      rem <= 1'b1;
    end
    step(3);
    chk(16'(act), 16'h0001);
    // Start with up already held, climb to the clamp, then hold and save.
    exp_q.push_back(LO);
    push_ramp(LO, HI);
    set_cmd(5'b00101);
    step(150);
    set_cmd(5'b00111);
    step(40);
    chk(16'(nvv), 16'h0001);
    chk(nvf, HI);
    exp_q.push_back(inch_f);
    set_cmd(5'b01111);
    step(20);
    exp_q.push_back(16'h0000);
    set_cmd(5'b01000);
    step(10);
    set_cmd(5'b00000);
    step(10);
    // Restart from the saved value, then ramp down to the floor.
    exp_q.push_back(HI);
    set_cmd(5'b00100);
    step(20);
    push_ramp(HI, LO);
    set_cmd(5'b00110);
    step(150);
    @(posedge clk) rem <= 1'b0;
    set_cmd(5'b00101);
    step(30);
    set_cmd(5'b00100);
    step(6);
    @(posedge clk) rem <= 1'b1;
    exp_q.push_back(16'h0000);
    @(posedge clk) func <= 8'h21;
    step(3);
    chk(16'(act), 16'h0000);
    set_cmd(5'b00000);
    step(6);
    @(posedge clk) func <= 8'h22;
    reg_wr(16'h0164, 16'h0000);
    step(3);
    chk(16'(nvv), 16'h0000);
    reg_wr(16'h0164, 16'h0001);
    // Save the floor, then wipe it with each initialisation code.
    for (int i = 8; i <= 9; i++) begin
      exp_q.push_back(LO);
      exp_q.push_back(16'h0000);
      set_cmd(i == 9 ? 5'b10000 : 5'b00100);
      step(40);
      set_cmd(5'b00000);
      step(10);
      chk(16'(nvv), 16'h0001);
      chk(nvf, LO);
      @(posedge clk) begin
        iwr <= 1'b1;
        isel <= 8'(i);
      end
      @(posedge clk) iwr <= 1'b0;
      step(3);
      chk(16'(nvv), 16'h0000);
    end
    // Power loss with a lower maximum: the kept value returns, clamped.
    @(posedge clk) begin
      rst_n <= 1'b0;
      nvv_in <= 1'b1;
      nvf_in <= 16'(16'h0011 + rnd() % 23);
      fmax <= 16'h0018;
    end
    step(3);
    chk(16'(nvv), 16'h0000);
    @(posedge clk) begin
      rst_n <= 1'b1;
      wr <= 1'b1;
      addr <= 16'h0164;
      wd <= 16'h0001;
    end
    @(posedge clk) wr <= 1'b0;
    step(2);
    chk(16'(nvv), 16'h0001);
    chk(nvf, nvf_in);
    exp_q.push_back(nvf_in > 16'h0018 ? 16'h0018 : nvf_in);
    exp_q.push_back(16'h0000);
    set_cmd(5'b00100);
    step(10);
    chk(16'(run), 16'h0001);
    set_cmd(5'b00000);
    step(10);
    chk(16'(exp_q.size()), 16'h0000);
    chk(16'(saves > 2), 16'h0001);
    wrap_up();
  end
endmodule : updown_frequency_memory_tb
